// ---- rtl/oht_pkg.sv ----
/*
  Shared constants, types and helpers for the host command timing block.
  Assumes a single 100 MHz device clock.
*/
package oht_pkg;
  // Clock and serial timing
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int BAUD = 38400;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;

  // Reply timeout, kept in units of 4 ms
  localparam int TOUT_DEF_MS = 200;
  localparam int TOUT_UNIT_MS = 4;
  localparam logic [7:0] TOUT_RESET = 8'(TOUT_DEF_MS / TOUT_UNIT_MS);
  localparam logic [9:0] ADAPT_MARGIN_MS = 10'h004;
  localparam logic [9:0] ADAPT_MIN_MS = 10'h008;

  // Vehicle bus idle gap and busy limit, in ms
  localparam int GAP_MS = 5;
  localparam int BUSY_MS = 100;

  // Transmit buffer
  localparam int BUF_DEPTH = 256;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TOUT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ADAPT = 8'h0c;

  // Field positions and reset values
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_AUTO_BIT = 2;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic AUTO_RESET = 1'b1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_CONN_BIT = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_AUTO_BIT = 4;
  localparam int ST_RESP_LSB = 8;
  localparam int ST_LEVEL_LSB = 16;

  // Characters
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_PROMPT = 8'h3e;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;

  typedef enum logic [1:0] {AD_OFF, AD_NORMAL, AD_AGGR} oht_adapt_t;

  typedef enum logic [3:0] {
    M_NONE, M_OK, M_QUERY, M_NODATA, M_BFULL, M_BBUSY,
    M_BERR, M_CANERR, M_DATAERR, M_STOPPED, M_UNABLE
  } oht_msg_id_t;

  typedef struct packed {
    logic [135:0] text;
    logic [4:0] len;
  } oht_msg_t;

  // Command line collected from the host
  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] last;
    logic [5:0] nchar;
    logic [5:0] hex_n;
    logic [5:0] tok_len;
    logic [1:0] ntok;
    logic all_hex;
  } oht_line_t;

  // Report text, right aligned, first character at byte len-1
  function automatic oht_msg_t msg_rom(input oht_msg_id_t id);
    oht_msg_t m;
    m = '0;
    unique case (id)
      M_NONE: m = '0;
      M_OK: m = '{136'("OK"), 5'd2};
      M_QUERY: m = '{136'("?"), 5'd1};
      M_NODATA: m = '{136'("NO DATA"), 5'd7};
      M_BFULL: m = '{136'("BUFFER FULL"), 5'd11};
      M_BBUSY: m = '{136'("BUS BUSY"), 5'd8};
      M_BERR: m = '{136'("BUS ERROR"), 5'd9};
      M_CANERR: m = '{136'("CAN ERROR"), 5'd9};
      M_DATAERR: m = '{136'("DATA ERROR"), 5'd10};
      M_STOPPED: m = '{136'("STOPPED"), 5'd7};
      M_UNABLE: m = '{136'("UNABLE TO CONNECT"), 5'd17};
      default: m = '0;
    endcase
    return m;
  endfunction : msg_rom

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= 8'h30) && (c <= 8'h39);
  endfunction : is_digit

  function automatic logic is_hex(input logic [7:0] c);
    return is_digit(c) || ((c >= 8'h41) && (c <= 8'h46)) ||
           ((c >= 8'h61) && (c <= 8'h66));
  endfunction : is_hex
endpackage : oht_pkg

// ---- rtl/oht_uart.sv ----
/*
  Asynchronous serial port toward the host, 8N1, lines idle high.
  Assumes rx_pin is asynchronous; everything else is on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module oht_uart #(
  parameter int BIT_CYCLES = oht_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  localparam int CW = $clog2(BIT_CYCLES + 1);

  logic [9:0] tx_sh, next_tx_sh;
  logic [3:0] tx_n, next_tx_n;
  logic [CW-1:0] tx_cnt, next_tx_cnt;
  logic [1:0] rx_sync;
  logic rx_act, next_rx_act;
  logic [3:0] rx_n, next_rx_n;
  logic [CW-1:0] rx_cnt, next_rx_cnt;
  logic [7:0] rx_sh, next_rx_sh;
  logic next_rx_valid;
  logic [7:0] next_rx_data;

  assign tx_ready = (tx_n == 4'h0);
  assign tx_pin = tx_sh[0];

  // Transmit shifter, idles at all ones
  always_comb begin
    next_tx_sh = tx_sh;
    next_tx_n = tx_n;
    next_tx_cnt = tx_cnt;
    if (tx_n == 4'h0) begin
      if (tx_valid) begin
        next_tx_sh = {1'b1, tx_data, 1'b0};
        next_tx_n = 4'ha;
        next_tx_cnt = CW'(BIT_CYCLES - 1);
      end
    end else if (tx_cnt != '0) begin
      next_tx_cnt = tx_cnt - 1'b1;
    end else begin
      next_tx_sh = {1'b1, tx_sh[9:1]};
      next_tx_n = tx_n - 1'b1;
      next_tx_cnt = CW'(BIT_CYCLES - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_sh <= '1;
      tx_n <= 4'h0;
      tx_cnt <= '0;
    end else begin
      tx_sh <= next_tx_sh;
      tx_n <= next_tx_n;
      tx_cnt <= next_tx_cnt;
    end
  end

  // Receiver, sampling mid bit after the two-stage synchroniser
  always_comb begin
    next_rx_act = rx_act;
    next_rx_n = rx_n;
    next_rx_cnt = rx_cnt;
    next_rx_sh = rx_sh;
    next_rx_valid = 1'b0;
    next_rx_data = rx_data;
    if (!rx_act) begin
      if (!rx_sync[1]) begin
        next_rx_act = 1'b1;
        next_rx_n = 4'h0;
        next_rx_cnt = CW'(BIT_CYCLES / 2);
      end
    end else if (rx_cnt != '0) begin
      next_rx_cnt = rx_cnt - 1'b1;
    end else begin
      next_rx_cnt = CW'(BIT_CYCLES - 1);
      next_rx_n = rx_n + 1'b1;
      if (rx_n == 4'h0) begin
        next_rx_act = !rx_sync[1]; // Glitch, not a start bit
      end else if (rx_n < 4'h9) begin
        next_rx_sh = {rx_sync[1], rx_sh[7:1]};
      end else begin
        next_rx_act = 1'b0;
        next_rx_valid = rx_sync[1];
        next_rx_data = rx_sync[1] ? rx_sh : rx_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_sync <= 2'h3;
      rx_act <= 1'b0;
      rx_n <= 4'h0;
      rx_cnt <= '0;
      rx_sh <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_sync <= {rx_sync[0], rx_pin};
      rx_act <= next_rx_act;
      rx_n <= next_rx_n;
      rx_cnt <= next_rx_cnt;
      rx_sh <= next_rx_sh;
      rx_valid <= next_rx_valid;
      rx_data <= next_rx_data;
    end
  end
endmodule : oht_uart
`default_nettype wire

// ---- rtl/oht_core.sv ----
/*
  Host command handling: command line, reply timeout with adaptive
  adjustment, response count, busy/interrupt handshake, transmit buffer
  and text reports. Avalon-MM slave for control and status.
  Assumes the vehicle-side inputs come from logic on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module oht_core #(
  parameter int MS_CYCLES = oht_pkg::MS_CYCLES,
  parameter int BIT_CYCLES = oht_pkg::BIT_CYCLES,
  parameter int BUF_DEPTH = oht_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic host_rx,
  output logic host_tx,
  input wire logic host_rts_n,
  output logic host_busy,
  output logic veh_init,
  input wire logic veh_init_ok,
  input wire logic veh_init_fail,
  output logic veh_req,
  output logic [5:0] veh_req_len,
  input wire logic veh_bus_active,
  input wire logic veh_reply,
  input wire logic veh_rx_valid,
  input wire logic [7:0] veh_rx_data,
  input wire logic veh_bus_err,
  input wire logic veh_can_err,
  input wire logic veh_data_err
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam int PW = $clog2(MS_CYCLES + 1);

  typedef enum logic [2:0] {S_IDLE, S_SEARCH, S_GAP, S_WAIT, S_REPORT, S_PROMPT} oht_state_t;

  oht_state_t state, next_state;
  oht_pkg::oht_line_t line, next_line;
  oht_pkg::oht_msg_id_t rep_id, next_rep_id;
  oht_pkg::oht_msg_t msg;
  oht_pkg::oht_adapt_t mode, next_mode;
  logic [4:0] rep_idx, next_rep_idx;
  logic [PW-1:0] pre, next_pre;
  logic [9:0] tmr_ms, next_tmr_ms, gap_idle, next_gap_idle, gap_tot, next_gap_tot;
  logic [9:0] adapt_ms, next_adapt_ms, tout_ms, set_ms;
  logic [7:0] resp_cnt, next_resp_cnt, tout_set, next_tout_set;
  logic [3:0] want, next_want;
  logic auto_s, next_auto_s, conn, next_conn;
  logic next_veh_init, next_veh_req, next_busy;
  logic [5:0] next_req_len;
  logic [1:0] rts_sync;
  logic tick, intr, has_cnt;
  logic [31:0] next_rdata;
  logic ack, next_ack, bus_wr;
  logic tx_valid, tx_ready, tx_fire, rx_valid;
  logic [7:0] tx_data, rx_data, rep_char;
  logic [7:0] mem [BUF_DEPTH];
  logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr, level;
  logic buf_empty, buf_full, push, drop;

  // Adaptive timeout from one measured reply time
  function automatic logic [9:0] adapt_calc(input oht_pkg::oht_adapt_t md,
                                            input logic [9:0] meas,
                                            input logic [9:0] lim);
    logic [11:0] c;
    c = (md == oht_pkg::AD_AGGR) ? {2'b00, meas} + {3'b000, meas[9:1]}
                                 : {1'b0, meas, 1'b0};
    c = c + {2'b00, oht_pkg::ADAPT_MARGIN_MS};
    if (c > {2'b00, lim}) c = {2'b00, lim};
    if (c < {2'b00, oht_pkg::ADAPT_MIN_MS}) c = {2'b00, oht_pkg::ADAPT_MIN_MS};
    return c[9:0];
  endfunction : adapt_calc

  oht_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .clk(clk),
    .reset_n(reset_n),
    .rx_pin(host_rx),
    .tx_pin(host_tx),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  // Interrupt request pin synchroniser
  always_ff @(posedge clk) begin
    if (!reset_n) rts_sync <= 2'h3;
    else rts_sync <= {rts_sync[0], host_rts_n};
  end

  assign intr = rx_valid || !rts_sync[1];
  assign set_ms = {tout_set, 2'b00};
  assign tout_ms = (mode == oht_pkg::AD_OFF) ? set_ms : adapt_ms;
  assign tick = (pre == PW'(MS_CYCLES - 1));
  assign msg = oht_pkg::msg_rom(rep_id);
  assign has_cnt = line.all_hex && (line.ntok >= 2'h2) && (line.tok_len == 6'h01) &&
                   oht_pkg::is_digit(line.last) && (line.last != oht_pkg::CH_0);

  // Transmit buffer, drained ahead of any report
  assign level = wr_ptr - rd_ptr;
  assign buf_empty = (level == '0);
  assign buf_full = (level == (AW+1)'(BUF_DEPTH));
  assign push = veh_rx_valid && (state == S_WAIT) && !buf_full;
  assign drop = veh_rx_valid && (state == S_WAIT) && buf_full;
  assign rep_char = (state == S_PROMPT) ? oht_pkg::CH_PROMPT :
                    (rep_idx == 5'h01) ? oht_pkg::CH_CR :
                    msg.text[8*(rep_idx - 5'h02) +: 8];
  assign tx_valid = !buf_empty || (state == S_PROMPT) ||
                    ((state == S_REPORT) && (rep_idx != 5'h00));
  assign tx_data = buf_empty ? rep_char : mem[rd_ptr[AW-1:0]];
  assign tx_fire = tx_valid && tx_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = (tx_fire && !buf_empty) ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) mem[wr_ptr[AW-1:0]] <= veh_rx_data;
  end

  // Avalon slave: one wait cycle, then the answer
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign bus_wr = avs_write && ack;

  always_comb begin
    next_ack = (avs_read || avs_write) && !ack;
    next_rdata = 32'h0;
    unique case (avs_address)
      oht_pkg::REG_CTRL: begin
        next_rdata[oht_pkg::CTRL_MODE_LSB +: 2] = mode;
        next_rdata[oht_pkg::CTRL_AUTO_BIT] = auto_s;
      end
      oht_pkg::REG_TOUT: next_rdata[7:0] = tout_set;
      oht_pkg::REG_STATUS: begin
        next_rdata[oht_pkg::ST_BUSY_BIT] = host_busy;
        next_rdata[oht_pkg::ST_CONN_BIT] = conn;
        next_rdata[oht_pkg::ST_MODE_LSB +: 2] = mode;
        next_rdata[oht_pkg::ST_AUTO_BIT] = auto_s;
        next_rdata[oht_pkg::ST_RESP_LSB +: 8] = resp_cnt;
        next_rdata[oht_pkg::ST_LEVEL_LSB +: AW+1] = level;
      end
      oht_pkg::REG_ADAPT: next_rdata[9:0] = tout_ms;
      default: next_rdata = 32'h0;
    endcase
    if (!next_ack) next_rdata = avs_readdata;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack <= next_ack;
      avs_readdata <= next_rdata;
    end
  end

  // Command, timing and report sequencer
  always_comb begin
    next_state = state;
    next_line = line;
    next_rep_id = rep_id;
    next_rep_idx = rep_idx;
    next_pre = tick ? '0 : pre + 1'b1;
    next_tmr_ms = (tick && tmr_ms != 10'h3ff) ? tmr_ms + 1'b1 : tmr_ms;
    next_gap_idle = veh_bus_active ? 10'h0 : (tick ? gap_idle + 1'b1 : gap_idle);
    next_gap_tot = tick ? gap_tot + 1'b1 : gap_tot;
    next_adapt_ms = adapt_ms;
    next_resp_cnt = resp_cnt;
    next_tout_set = tout_set;
    next_want = want;
    next_mode = mode;
    next_auto_s = auto_s;
    next_conn = conn;
    next_veh_init = 1'b0;
    next_veh_req = 1'b0;
    next_req_len = veh_req_len;
    if (bus_wr && avs_address == oht_pkg::REG_CTRL) begin
      next_mode = oht_pkg::oht_adapt_t'(avs_writedata[oht_pkg::CTRL_MODE_LSB +: 2]);
      next_auto_s = avs_writedata[oht_pkg::CTRL_AUTO_BIT];
      next_conn = 1'b0;
    end
    if (bus_wr && avs_address == oht_pkg::REG_TOUT) begin
      next_tout_set = avs_writedata[7:0];
      next_adapt_ms = {avs_writedata[7:0], 2'b00};
    end
    unique case (state)
      S_IDLE: begin
        if (rx_valid) begin
          if (rx_data == oht_pkg::CH_CR) begin
            next_line = '0;
            next_line.all_hex = 1'b1;
            next_rep_idx = 5'h00;
            next_want = has_cnt ? line.last[3:0] : 4'h0;
            next_req_len = line.hex_n - {5'h00, has_cnt};
            if (line.nchar == 6'h00) begin
              next_state = S_PROMPT;
            end else if (line.nchar == 6'h03 && line.c0 == oht_pkg::CH_A &&
                         line.c1 == oht_pkg::CH_T && line.c2[7:2] == 6'h0c &&
                         line.c2[1:0] != 2'h3) begin
              next_mode = oht_pkg::oht_adapt_t'(line.c2[1:0]);
              next_rep_id = oht_pkg::M_OK;
              next_rep_idx = 5'h03;
              next_state = S_REPORT;
            end else if (line.all_hex) begin
              next_pre = '0;
              next_gap_idle = 10'h0;
              next_gap_tot = 10'h0;
              next_veh_init = auto_s && !conn;
              next_state = (auto_s && !conn) ? S_SEARCH : S_GAP;
            end else begin
              next_rep_id = oht_pkg::M_QUERY;
              next_rep_idx = 5'h02;
              next_state = S_REPORT;
            end
          end else if (rx_data == oht_pkg::CH_SP) begin
            next_line.tok_len = 6'h00;
          end else if (rx_data != oht_pkg::CH_LF && line.nchar != 6'h3f) begin
            next_line.nchar = line.nchar + 1'b1;
            if (line.nchar == 6'h00) next_line.c0 = rx_data;
            if (line.nchar == 6'h01) next_line.c1 = rx_data;
            if (line.nchar == 6'h02) next_line.c2 = rx_data;
            next_line.last = rx_data;
            next_line.all_hex = line.all_hex && oht_pkg::is_hex(rx_data);
            next_line.hex_n = line.hex_n + {5'h00, oht_pkg::is_hex(rx_data)};
            next_line.tok_len = line.tok_len + 1'b1;
            if (line.tok_len == 6'h00 && line.ntok != 2'h3) next_line.ntok = line.ntok + 1'b1;
          end
        end
      end
      S_SEARCH: begin
        // Bus, CAN and data errors are not reported while searching
        if (intr) begin
          next_rep_id = oht_pkg::M_STOPPED;
          next_rep_idx = 5'h08;
          next_state = S_REPORT;
        end else if (veh_init_ok) begin
          next_conn = 1'b1;
          next_pre = '0;
          next_gap_idle = 10'h0;
          next_gap_tot = 10'h0;
          next_state = S_GAP;
        end else if (veh_init_fail) begin
          next_rep_id = oht_pkg::M_UNABLE;
          next_rep_idx = 5'h12;
          next_state = S_REPORT;
        end
      end
      S_GAP: begin
        if (intr) begin
          next_state = S_PROMPT;
        end else if (next_gap_idle >= 10'(oht_pkg::GAP_MS)) begin
          next_veh_req = 1'b1;
          next_pre = '0;
          next_tmr_ms = 10'h0;
          next_resp_cnt = 8'h00;
          next_state = S_WAIT;
        end else if (gap_tot >= 10'(oht_pkg::BUSY_MS)) begin
          next_rep_id = oht_pkg::M_BBUSY;
          next_rep_idx = 5'h09;
          next_state = S_REPORT;
        end
      end
      S_WAIT: begin
        next_rep_idx = 5'h00;
        if (intr) begin
          next_state = S_PROMPT;
        end else if (veh_bus_err || veh_can_err || veh_data_err || drop) begin
          next_rep_id = veh_bus_err ? oht_pkg::M_BERR :
                        veh_can_err ? oht_pkg::M_CANERR :
                        veh_data_err ? oht_pkg::M_DATAERR :
                        oht_pkg::M_BFULL;
          next_rep_idx = msg_len_plus_cr(next_rep_id);
          next_state = S_REPORT;
        end else if (veh_reply) begin
          next_resp_cnt = resp_cnt + 1'b1;
          next_pre = '0;
          next_tmr_ms = 10'h0;
          if (mode != oht_pkg::AD_OFF) next_adapt_ms = adapt_calc(mode, tmr_ms, set_ms);
          if (want != 4'h0 && next_resp_cnt == {4'h0, want}) next_state = S_REPORT;
        end else if (tmr_ms >= tout_ms) begin
          if (resp_cnt == 8'h00) begin
            next_rep_id = oht_pkg::M_NODATA;
            next_rep_idx = 5'h08;
          end
          next_state = S_REPORT;
        end
      end
      S_REPORT: begin
        if (rep_idx == 5'h00) next_state = S_PROMPT;
        else if (tx_fire && buf_empty) next_rep_idx = rep_idx - 1'b1;
      end
      S_PROMPT: begin
        if (tx_fire && buf_empty) next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    next_busy = (next_state != S_IDLE);
  end

  function automatic logic [4:0] msg_len_plus_cr(input oht_pkg::oht_msg_id_t id);
    oht_pkg::oht_msg_t m;
    m = oht_pkg::msg_rom(id);
    return m.len + 5'h01;
  endfunction : msg_len_plus_cr

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= S_IDLE;
      line <= '{8'h0, 8'h0, 8'h0, 8'h0, 6'h0, 6'h0, 6'h0, 2'h0, 1'b1};
      rep_id <= oht_pkg::M_NONE;
      rep_idx <= 5'h00;
      pre <= '0;
      tmr_ms <= 10'h0;
      gap_idle <= 10'h0;
      gap_tot <= 10'h0;
      adapt_ms <= {oht_pkg::TOUT_RESET, 2'b00};
      resp_cnt <= 8'h00;
      tout_set <= oht_pkg::TOUT_RESET;
      want <= 4'h0;
      mode <= oht_pkg::oht_adapt_t'(oht_pkg::MODE_RESET);
      auto_s <= oht_pkg::AUTO_RESET;
      conn <= 1'b0;
      veh_init <= 1'b0;
      veh_req <= 1'b0;
      veh_req_len <= 6'h00;
      host_busy <= 1'b0;
    end else begin
      state <= next_state;
      line <= next_line;
      rep_id <= next_rep_id;
      rep_idx <= next_rep_idx;
      pre <= next_pre;
      tmr_ms <= next_tmr_ms;
      gap_idle <= next_gap_idle;
      gap_tot <= next_gap_tot;
      adapt_ms <= next_adapt_ms;
      resp_cnt <= next_resp_cnt;
      tout_set <= next_tout_set;
      want <= next_want;
      mode <= next_mode;
      auto_s <= next_auto_s;
      conn <= next_conn;
      veh_init <= next_veh_init;
      veh_req <= next_veh_req;
      veh_req_len <= next_req_len;
      host_busy <= next_busy;
    end
  end
endmodule : oht_core
`default_nettype wire

// ---- verif/oht_core_sva.sv ----
/* Port checker for oht_core. Assumes a bind that passes the core counts. */
`timescale 1ns/10ps
`default_nettype none
module oht_chk #(parameter int MS_CYCLES = 100, parameter int BIT_CYCLES = 8) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic host_rx,
  input wire logic host_tx,
  input wire logic host_rts_n,
  input wire logic host_busy,
  input wire logic veh_init,
  input wire logic veh_req,
  input wire logic veh_bus_active
);
  int quiet;
  int idle;
  // Cycles since host_rx low and since bus activity
  always_ff @(posedge clk) begin
    quiet <= (!reset_n || !host_rx) ? 0 : quiet + 1;
    idle <= (!reset_n || veh_bus_active) ? 0 : idle + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wait_one_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
  tx_start_a: assert property ($fell(host_tx) |-> !host_tx [*6])
    else $error("short start bit");
  req_pulse_a: assert property (veh_req |=> !veh_req)
    else $error("request not a pulse");
  busy_req_a: assert property (veh_req |-> host_busy)
    else $error("request while idle");
  init_busy_a: assert property (veh_init |-> host_busy ##1 !veh_init)
    else $error("bad search start");
  bus_gap_a: assert property (veh_req |-> idle >= 4 * MS_CYCLES)
    else $error("no idle gap");
  stay_idle_a: assert property ($rose(host_busy) |-> quiet < 12 * BIT_CYCLES)
    else $error("busy without command");
  intr_stop_a: assert property ($fell(host_rts_n) && host_busy |-> ##[1:1000] !host_busy)
    else $error("interrupt ignored");
endmodule : oht_chk
`default_nettype wire

// ---- verif/oht_host.sv ----
/* Host model on the serial link. Assumes clk at the device rate. */
`timescale 1ns/10ps
`default_nettype none
module oht_host #(parameter int BIT_CYCLES = 8) (
  input wire logic clk,
  input wire logic host_tx,
  output logic host_rx,
  output logic host_rts_n
);
  logic [127:0] rx_sh = '0;
  logic [7:0] b;
  initial host_rx = 1'b1;
  initial host_rts_n = 1'b1;
  // One frame, start bit, LSB first, stop bit
  task automatic put(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_rx <= f[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask : put
  task automatic send(input string s);
    rx_sh = '0;
    foreach (s[i]) put(8'(s[i]));
    put(8'h0d);
  endtask : send
  task automatic pull(input logic v);
    host_rts_n <= v;
  endtask : pull
  // Collect reply bytes, sampled mid-bit
  initial forever begin
    @(negedge host_tx);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      b[i] = host_tx;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    rx_sh = {rx_sh[119:0], b};
  end
endmodule : oht_host
`default_nettype wire

// ---- verif/tb.sv ----
/* Bench for oht_core and host model. Assumes shortened ms and bit counts. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int BITC = 8;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, host_rx, host_tx, host_rts_n, host_busy, veh_init, veh_req;
  logic [5:0] veh_req_len;
  logic veh_init_ok = 1'b0;
  logic veh_init_fail = 1'b0;
  logic veh_reply = 1'b0;
  logic veh_bus_active = 1'b0;
  logic veh_rx_valid = 1'b0;
  logic [7:0] veh_rx_data = 8'h00;
  logic veh_bus_err = 1'b0, veh_can_err = 1'b0, veh_data_err = 1'b0;
  logic [2:0] ec [3] = '{3'h4, 3'h3, 3'h1};
  logic [127:0] ev [3] = '{128'({8'h41, "BUS ERROR", 8'h0d, 8'h3e}),
    128'({8'h41, "CAN ERROR", 8'h0d, 8'h3e}), 128'({8'h41, "DATA ERROR", 8'h0d, 8'h3e})};
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [31:0] rv [5] = '{32'h5, 32'h32, 32'h14, 32'hc8, 32'h0};
  always #5 clk = ~clk;
  oht_core #(.MS_CYCLES(100), .BIT_CYCLES(BITC)) DUT (.clk, .reset_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .host_rx,
    .host_tx, .host_rts_n, .host_busy, .veh_init, .veh_init_ok, .veh_init_fail, .veh_req,
    .veh_req_len, .veh_bus_active, .veh_reply, .veh_rx_valid, .veh_rx_data,
    .veh_bus_err, .veh_can_err, .veh_data_err);
  oht_host #(.BIT_CYCLES(BITC)) HOST (.clk, .host_tx, .host_rx, .host_rts_n);
  task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wait_out(input logic req);
    int k;
    k = 0;
    while ((req ? veh_req : veh_init) !== 1'b1 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    chk("start", 128'({host_busy, k < 9000}), 128'(2'h3));
  endtask : wait_out
  task automatic expect_msg(input string n, input logic [127:0] e, input int lim);
    int k;
    k = 0;
    while ((HOST.rx_sh[7:0] !== 8'h3e || host_busy !== 1'b0) && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk(n, HOST.rx_sh, e);
    repeat (2 * BITC) @(posedge clk);
    $display("test %s done", n);
  endtask : expect_msg
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reg", 128'(q), 128'(rv[i]));
    end
    bus(1'b1, 8'h04, 32'h0a);
    bus(1'b0, 8'h04, 32'h0);
    chk("tout", 128'(q), 128'(32'h0a));
    for (int m = 2; m < 5; m++) begin
      HOST.send($sformatf("AT%0d", m % 3));
      expect_msg("mode", 128'({"OK", 8'h0d, 8'h3e}), 9000);
      bus(1'b0, 8'h00, 32'h0);
      chk("ctrl", 128'(q), 128'(32'h4 + m % 3));
    end
    HOST.send("XY");
    expect_msg("query", 128'({"?", 8'h0d, 8'h3e}), 9000);
    HOST.send("01 00");
    wait_out(1'b0);
    veh_init_fail <= 1'b1;
    @(posedge clk);
    veh_init_fail <= 1'b0;
    expect_msg("fail", 128'({"UNABLE TO CONNECT", 8'h0d, 8'h3e}), 9000);
    HOST.send("01 00");
    wait_out(1'b0);
    HOST.pull(1'b0);
    expect_msg("stop", 128'({"STOPPED", 8'h0d, 8'h3e}), 9000);
    HOST.pull(1'b1);
    HOST.send("01 00 2");
    wait_out(1'b0);
    veh_init_ok <= 1'b1;
    veh_bus_active <= 1'b1;
    @(posedge clk);
    veh_init_ok <= 1'b0;
    repeat (200) @(posedge clk);
    veh_bus_active <= 1'b0;
    wait_out(1'b1);
    chk("len", 128'(veh_req_len), 128'(6'h04));
    repeat (2) begin
      veh_reply <= 1'b1;
      @(posedge clk);
      veh_reply <= 1'b0;
      repeat (50) @(posedge clk);
    end
    expect_msg("count", 128'(8'h3e), 400);
    bus(1'b0, 8'h0c, 32'h0);
    chk("adapt", 128'(q), 128'(oht_pkg::ADAPT_MIN_MS));
    HOST.send("01 00");
    wait_out(1'b1);
    expect_msg("nodata", 128'({"NO DATA", 8'h0d, 8'h3e}), 9000);
    // Buffered byte, then an error pulse while waiting for replies
    for (int e = 0; e < 3; e++) begin
      HOST.send("01 00");
      wait_out(1'b1);
      veh_rx_valid <= 1'b1;
      veh_rx_data <= 8'h41;
      @(posedge clk);
      veh_rx_valid <= 1'b0;
      {veh_bus_err, veh_can_err, veh_data_err} <= ec[e];
      @(posedge clk);
      {veh_bus_err, veh_can_err, veh_data_err} <= 3'h0;
      expect_msg("error", ev[e], 9000);
    end
    end_of_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule : tb
bind oht_core oht_chk #(.MS_CYCLES(MS_CYCLES), .BIT_CYCLES(BIT_CYCLES)) CHK (.clk,
  .reset_n, .avs_read, .avs_waitrequest, .host_rx, .host_tx, .host_rts_n, .host_busy,
  .veh_init, .veh_req, .veh_bus_active);
`default_nettype wire
